// >>> pme_top.sv
`include "pme_regs.svh"
`default_nettype none
module pme_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // General ports
    input wire logic [7:0] first_port_lines_in,
    output pme_pkg::pme_port_t first_port_lines,
    input wire logic [7:0] second_port_lines_in,
    output pme_pkg::pme_port_t second_port_lines,
    input wire logic [7:0] third_port_lines_in,
    output pme_pkg::pme_port_t third_port_lines,
    input wire logic [7:0] third_port_alt_out,
    input wire logic [7:0] third_port_alt_oe,
    input wire logic [7:0] muxbus_port_lines_in,
    output pme_pkg::pme_port_t muxbus_port_lines,
    input wire logic [7:0] high_address_port_lines_in,
    output pme_pkg::pme_port_t high_address_port_lines,
    // Bus strobes
    output logic addr_latch_strobe,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic strobe_oe,
    // Memory-size select pins
    input wire logic memsize_select_lo_in,
    output logic memsize_select_lo_out,
    output logic memsize_select_lo_oe,
    input wire logic memsize_select_hi_in,
    output logic memsize_select_hi_out,
    output logic memsize_select_hi_oe,
    // Upper analog lines as digital inputs
    input wire logic [3:0] upper_analog_lines,
    // Piggyback socket
    output pme_pkg::pme_rom_t rom_socket,
    input wire logic [7:0] rom_socket_data
);
    // Software state
    logic [7:0] lat_a, dir_a, lat_b, dir_b, lat_c, dir_c, alt_c, lat_d, lat_f, dir_f;
    logic dir_d;
    logic [2:0] exp_mode;
    logic [1:0] mem_size;
    logic standby;
    logic romless;
    logic [13:0] prog_ctr;
    logic [3:0] an_prev;
    logic [3:0] an_fall;
    logic [1:0] memsel;
    logic memsel_taken;
    logic [26:0] xcmd;
    logic [7:0] xrdata;
    logic xfault;
    pme_pkg::pme_state_t state;
    pme_pkg::pme_state_t next_state;
    logic [3:0] phase_cnt;
    // AXI write channel holding
    logic aw_held, w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Byte merge used by every writable register except dir_d and the analog edge clear
    function automatic logic [31:0] pme_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : pme_merge

    // Address-bit mask of the high port per mode
    function automatic logic [7:0] pme_hmask(input logic [2:0] m);
        case (m)
            pme_pkg::PME_EXP_4K: return 8'h0F;
            pme_pkg::PME_EXP_16K: return 8'h3F;
            pme_pkg::PME_EXP_60K: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction : pme_hmask

    // Write decode
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire [31:0] wm = pme_merge(32'h0000_0000, w_data, w_strb);
    wire wr_a = wr_go && aw_addr == `PME_OFF_PORTA_OUT;
    wire wr_ad = wr_go && aw_addr == `PME_OFF_PORTA_DIR;
    wire wr_b = wr_go && aw_addr == `PME_OFF_PORTB_OUT;
    wire wr_bd = wr_go && aw_addr == `PME_OFF_PORTB_DIR;
    wire wr_c = wr_go && aw_addr == `PME_OFF_PORTC_OUT;
    wire wr_cd = wr_go && aw_addr == `PME_OFF_PORTC_DIR;
    wire wr_ca = wr_go && aw_addr == `PME_OFF_PORTC_ALT;
    wire wr_d = wr_go && aw_addr == `PME_OFF_PORTD_OUT;
    wire wr_dd = wr_go && aw_addr == `PME_OFF_PORTD_DIR;
    wire wr_f = wr_go && aw_addr == `PME_OFF_PORTF_OUT;
    wire wr_fd = wr_go && aw_addr == `PME_OFF_PORTF_DIR;
    wire wr_cfg = wr_go && aw_addr == `PME_OFF_CONFIG;
    wire wr_an = wr_go && aw_addr == `PME_OFF_ANALOG;
    wire wr_xc = wr_go && aw_addr == `PME_OFF_XCYCLE;
    wire wr_pc = wr_go && aw_addr == `PME_OFF_PC;
    wire wr_ok = wr_a | wr_ad | wr_b | wr_bd | wr_c | wr_cd | wr_ca | wr_d | wr_dd | wr_f | wr_fd
               | wr_cfg | wr_an | wr_xc | wr_pc;
    wire bus_busy = state != pme_pkg::PME_IDLE;
    wire [31:0] cfg_word = {22'h0, romless, standby, 2'h0, mem_size, 1'h0, exp_mode};
    wire [31:0] cfg_new = pme_merge(cfg_word, w_data, w_strb);
    // Expansion cycle start; internal RAM never goes to the external bus
    wire xc_ram = wm[`PME_XC_ADDR_LSB + 8 +: 8] == `PME_RAM_HI;
    wire xc_start = wr_xc && !bus_busy && exp_mode != pme_pkg::PME_EXP_NONE && !xc_ram;
    wire xc_reject = wr_xc && !xc_start;

    // Read decode
    logic [31:0] rd_mux;
    wire rd_hit = s_axi_araddr <= `PME_OFF_ROMDATA;
    always_comb begin
        case (s_axi_araddr)
            `PME_OFF_PORTA_OUT: rd_mux = {24'h0, lat_a};
            `PME_OFF_PORTA_DIR: rd_mux = {24'h0, dir_a};
            `PME_OFF_PORTB_OUT: rd_mux = {24'h0, lat_b};
            `PME_OFF_PORTB_DIR: rd_mux = {24'h0, dir_b};
            `PME_OFF_PORTC_OUT: rd_mux = {24'h0, lat_c};
            `PME_OFF_PORTC_DIR: rd_mux = {24'h0, dir_c};
            `PME_OFF_PORTC_ALT: rd_mux = {24'h0, alt_c};
            `PME_OFF_PORTD_OUT: rd_mux = {24'h0, lat_d};
            `PME_OFF_PORTD_DIR: rd_mux = {31'h0, dir_d};
            `PME_OFF_PORTF_OUT: rd_mux = {24'h0, lat_f};
            `PME_OFF_PORTF_DIR: rd_mux = {24'h0, dir_f};
            `PME_OFF_CONFIG: rd_mux = cfg_word;
            `PME_OFF_PINS_AB: rd_mux = {16'h0, second_port_lines_in, first_port_lines_in};
            `PME_OFF_PINS_CDF: rd_mux = {8'h0, high_address_port_lines_in, muxbus_port_lines_in,
                                         third_port_lines_in};
            `PME_OFF_ANALOG: rd_mux = {24'h0, an_fall, upper_analog_lines};
            `PME_OFF_XCYCLE: rd_mux = {5'h0, xcmd};
            `PME_OFF_XSTATUS: rd_mux = {20'h0, memsel, memsel_taken, xfault, xrdata};
            `PME_OFF_PC: rd_mux = {18'h0, prog_ctr};
            `PME_OFF_ROMDATA: rd_mux = {24'h0, rom_socket_data};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // AXI write address/data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PME_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_ok && !xc_reject) ? `PME_RESP_OKAY : `PME_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_held && aresetn;
    assign s_axi_wready = !w_held && aresetn;

    // AXI read channel, one cycle answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `PME_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? `PME_RESP_OKAY : `PME_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid && aresetn;

    // Port latches and directions; reset makes every line an input
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {lat_a, dir_a, lat_b, dir_b, lat_c, dir_c, alt_c} <= 56'h0;
            {lat_d, lat_f, dir_f} <= 24'h0;
            dir_d <= 1'b0;
        end else begin
            if (wr_a) lat_a <= pme_merge({24'h0, lat_a}, w_data, w_strb)[7:0];
            if (wr_ad) dir_a <= pme_merge({24'h0, dir_a}, w_data, w_strb)[7:0];
            if (wr_b) lat_b <= pme_merge({24'h0, lat_b}, w_data, w_strb)[7:0];
            if (wr_bd) dir_b <= pme_merge({24'h0, dir_b}, w_data, w_strb)[7:0];
            if (wr_c) lat_c <= pme_merge({24'h0, lat_c}, w_data, w_strb)[7:0];
            if (wr_cd) dir_c <= pme_merge({24'h0, dir_c}, w_data, w_strb)[7:0];
            if (wr_ca) alt_c <= pme_merge({24'h0, alt_c}, w_data, w_strb)[7:0];
            if (wr_d) lat_d <= pme_merge({24'h0, lat_d}, w_data, w_strb)[7:0];
            if (wr_dd && w_strb[0]) dir_d <= w_data[0];
            if (wr_f) lat_f <= pme_merge({24'h0, lat_f}, w_data, w_strb)[7:0];
            if (wr_fd) dir_f <= pme_merge({24'h0, dir_f}, w_data, w_strb)[7:0];
        end
    end

    // Configuration, program counter, socket enable; size ignored when mask-ROM
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            exp_mode <= 3'h0;
            mem_size <= 2'h0;
            standby <= 1'b0;
            romless <= 1'b0;
            prog_ctr <= 14'h0000;
        end else begin
            if (wr_cfg && !bus_busy) begin
                exp_mode <= (cfg_new[`PME_CFG_EXP_LSB +: 3] > 3'h4) ? 3'h0 : cfg_new[`PME_CFG_EXP_LSB +: 3];
                if (romless) mem_size <= (cfg_new[`PME_CFG_MEM_LSB +: 2] == 2'h3) ? 2'h2
                                         : cfg_new[`PME_CFG_MEM_LSB +: 2];
                standby <= cfg_new[`PME_CFG_STANDBY_BIT];
                romless <= cfg_new[`PME_CFG_ROMLESS_BIT];
            end
            if (wr_pc) prog_ctr <= pme_merge({18'h0, prog_ctr}, w_data, w_strb)[13:0];
        end
    end

    // Socket outputs registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rom_socket <= '{addr: 14'h0000, ce: 1'b0};
        end else begin
            rom_socket.addr <= prog_ctr;
            rom_socket.ce <= standby;
        end
    end

    // Falling edge capture; a new edge wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            an_prev <= 4'h0;
            an_fall <= 4'h0;
        end else begin
            an_prev <= upper_analog_lines;
            an_fall <= (an_fall & ~(wr_an && w_strb[0] ? w_data[7:4] : 4'h0))
                       | (an_prev & ~upper_analog_lines);
        end
    end

    // Size pins caught one edge after release, then reused as outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            memsel_taken <= 1'b0;
            memsel <= 2'h0;
        end else if (!memsel_taken) begin
            memsel_taken <= 1'b1;
            memsel <= {memsize_select_hi_in, memsize_select_lo_in};
        end
    end

    // Bus cycle sequencer: address + latch, hold, strobe, done
    always_comb begin
        next_state = state;
        case (state)
            pme_pkg::PME_IDLE: if (xc_start) next_state = pme_pkg::PME_ADDR;
            pme_pkg::PME_ADDR: if (phase_cnt == 4'h1) next_state = pme_pkg::PME_HOLD;
            pme_pkg::PME_HOLD: if (phase_cnt == 4'h1) next_state = pme_pkg::PME_STROBE;
            pme_pkg::PME_STROBE: if (phase_cnt == 4'h1) next_state = pme_pkg::PME_DONE;
            pme_pkg::PME_DONE: next_state = pme_pkg::PME_IDLE;
            default: next_state = pme_pkg::PME_IDLE;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= pme_pkg::PME_IDLE;
            phase_cnt <= 4'h0;
            xcmd <= 27'h0;
            xrdata <= 8'h00;
            xfault <= 1'b0;
        end else begin
            state <= next_state;
            if (xc_start) begin
                xcmd <= wm[26:0];
                phase_cnt <= `PME_ALE_CYC;
            end else if (next_state != state) begin
                phase_cnt <= (next_state == pme_pkg::PME_HOLD) ? `PME_HOLD_CYC : `PME_STB_CYC;
            end else if (phase_cnt != 4'h0) begin
                phase_cnt <= phase_cnt - 4'h1;
            end
            if (state == pme_pkg::PME_STROBE && phase_cnt == 4'h1 && !xcmd[`PME_XC_WRITE_BIT])
                xrdata <= muxbus_port_lines_in;
            xfault <= xc_reject ? 1'b1 : (wr_xc ? 1'b0 : xfault);
        end
    end

    // Pin drive: ports as I/O or bus, strobes, size pins
    wire in_ext = exp_mode != pme_pkg::PME_EXP_NONE;
    wire [7:0] hmask = pme_hmask(exp_mode);
    wire st_addr = state == pme_pkg::PME_ADDR;
    wire st_strobe = state == pme_pkg::PME_STROBE;
    wire st_cyc = bus_busy;
    wire is_wr = xcmd[`PME_XC_WRITE_BIT];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_port_lines <= '0;
            second_port_lines <= '0;
            third_port_lines <= '0;
            muxbus_port_lines <= '0;
            high_address_port_lines <= '0;
            addr_latch_strobe <= 1'b0;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            strobe_oe <= 1'b0;
            memsize_select_lo_out <= 1'b1;
            memsize_select_hi_out <= 1'b1;
            memsize_select_lo_oe <= 1'b0;
            memsize_select_hi_oe <= 1'b0;
        end else begin
            first_port_lines <= '{out: lat_a, oe: dir_a};
            second_port_lines <= '{out: lat_b, oe: dir_b};
            third_port_lines <= '{out: (alt_c & third_port_alt_out) | (~alt_c & lat_c),
                                  oe: (alt_c & third_port_alt_oe) | (~alt_c & dir_c)};
            if (in_ext) begin
                // Address only in the latch phase, data only in the hold and strobe phases of a write
                muxbus_port_lines.out <= st_addr ? xcmd[7:0] : xcmd[`PME_XC_DATA_LSB +: 8];
                muxbus_port_lines.oe <= {8{st_addr || ((st_strobe || state == pme_pkg::PME_HOLD) && is_wr)}};
            end else begin
                muxbus_port_lines <= '{out: lat_d, oe: {8{dir_d}}};
            end
            high_address_port_lines.out <= (hmask & xcmd[15:8]) | (~hmask & lat_f);
            high_address_port_lines.oe <= hmask | dir_f;
            addr_latch_strobe <= st_addr;
            read_strobe_n <= !(st_strobe && !is_wr);
            write_strobe_n <= !(st_strobe && is_wr);
            strobe_oe <= in_ext;
            memsize_select_lo_out <= !(st_cyc && xcmd[`PME_XC_IO_BIT]);
            memsize_select_hi_out <= !(st_cyc && xcmd[`PME_XC_FETCH_BIT]);
            memsize_select_lo_oe <= memsel_taken;
            memsize_select_hi_oe <= memsel_taken;
        end
    end
endmodule : pme_top
`default_nettype wire

// >>> pme_regs.svh
`ifndef PME_REGS_SVH
`define PME_REGS_SVH
// Register byte offsets
`define PME_OFF_PORTA_OUT   12'h000
`define PME_OFF_PORTA_DIR   12'h004
`define PME_OFF_PORTB_OUT   12'h008
`define PME_OFF_PORTB_DIR   12'h00C
`define PME_OFF_PORTC_OUT   12'h010
`define PME_OFF_PORTC_DIR   12'h014
`define PME_OFF_PORTC_ALT   12'h018
`define PME_OFF_PORTD_OUT   12'h01C
`define PME_OFF_PORTD_DIR   12'h020
`define PME_OFF_PORTF_OUT   12'h024
`define PME_OFF_PORTF_DIR   12'h028
`define PME_OFF_CONFIG      12'h02C
`define PME_OFF_PINS_AB     12'h030
`define PME_OFF_PINS_CDF    12'h034
`define PME_OFF_ANALOG      12'h038
`define PME_OFF_XCYCLE      12'h03C
`define PME_OFF_XSTATUS     12'h040
`define PME_OFF_PC          12'h044
`define PME_OFF_ROMDATA     12'h048
// Config field positions
`define PME_CFG_EXP_LSB     0
`define PME_CFG_MEM_LSB     4
`define PME_CFG_STANDBY_BIT 8
`define PME_CFG_ROMLESS_BIT 9
// Expansion cycle command fields
`define PME_XC_ADDR_LSB     0
`define PME_XC_DATA_LSB     16
`define PME_XC_WRITE_BIT    24
`define PME_XC_IO_BIT       25
`define PME_XC_FETCH_BIT    26
// Internal RAM window base (high byte)
`define PME_RAM_HI          8'hFF
// Cycle phase lengths in clocks
`define PME_ALE_CYC         4'h2
`define PME_HOLD_CYC        4'h1
`define PME_STB_CYC         4'h3
// AXI responses
`define PME_RESP_OKAY       2'h0
`define PME_RESP_SLVERR     2'h2
`endif

// >>> pme_pkg.sv
`default_nettype none
package pme_pkg;
    // Expansion mode encoding
    typedef enum logic [2:0] {
        PME_EXP_NONE = 3'h0,
        PME_EXP_256 = 3'h1,
        PME_EXP_4K = 3'h2,
        PME_EXP_16K = 3'h3,
        PME_EXP_60K = 3'h4
    } pme_exp_t;
    // Bus cycle states
    typedef enum logic [2:0] {
        PME_IDLE = 3'h0,
        PME_ADDR = 3'h1,
        PME_HOLD = 3'h2,
        PME_STROBE = 3'h3,
        PME_DONE = 3'h4
    } pme_state_t;
    // One three-state port as outputs and enables
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pme_port_t;
    // Piggyback socket signals
    typedef struct packed {
        logic [13:0] addr;
        logic ce;
    } pme_rom_t;
endpackage : pme_pkg
`default_nettype wire

// >>> pme_xmem.sv
`default_nettype none
module pme_xmem (
    // Bus from the device
    input wire logic aclk,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire pme_pkg::pme_port_t lo,
    input wire pme_pkg::pme_port_t hi,
    // Level on the multiplexed lines
    output logic [7:0] bus
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [7:0] alat;
    logic [7:0] last;
    // Latch takes the low address under the strobe, memory stores under write
    always_ff @(posedge aclk) begin
        if (ale) alat <= lo.out;
        if (!wr_n) mem[{hi.out, alat}] <= lo.out;
        last <= bus;
    end
    // Memory drives only under read; a free bus toggles so nothing stale passes
    assign bus = !rd_n ? mem[{hi.out, alat}] : (lo.oe == 8'hFF ? lo.out : ~last);
endmodule : pme_xmem
`default_nettype wire

// >>> pme_top_props.sv
`default_nettype none
module pme_top_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus pins
    input wire logic addr_latch_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire pme_pkg::pme_port_t muxbus_port_lines,
    input wire logic memsize_select_lo_oe,
    input wire logic memsize_select_hi_oe
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Reset and size pin turnaround
    property p_rst;
        $rose(aresetn) |-> read_strobe_n && write_strobe_n;
    endproperty
    a_rst: assert property (p_rst) else $error("strobe low after reset");
    property p_size;
        $rose(aresetn) |-> !memsize_select_lo_oe ##[1:3] memsize_select_lo_oe && memsize_select_hi_oe;
    endproperty
    a_size: assert property (p_size) else $error("size pins not turned");
    // Address phase comes first, two cycles with the bus driven
    property p_first;
        $fell(read_strobe_n) || $fell(write_strobe_n) |-> $past(addr_latch_strobe, 2) && !$past(addr_latch_strobe);
    endproperty
    a_first: assert property (p_first) else $error("strobe without address");
    property p_ale;
        $rose(addr_latch_strobe) |-> muxbus_port_lines.oe == 8'hFF ##1 addr_latch_strobe ##1 !addr_latch_strobe;
    endproperty
    a_ale: assert property (p_ale) else $error("bad address phase");
    // Strobe phases: bus released on read, data held on write
    property p_rd;
        $fell(read_strobe_n) |-> (!read_strobe_n && muxbus_port_lines.oe == 8'h00) [*3] ##1 read_strobe_n;
    endproperty
    a_rd: assert property (p_rd) else $error("bad read strobe");
    property p_wr;
        $fell(write_strobe_n) |-> (!write_strobe_n && $stable(muxbus_port_lines.out)) [*3] ##1 write_strobe_n;
    endproperty
    a_wr: assert property (p_wr) else $error("bad write strobe");
    property p_excl;
        !(read_strobe_n && write_strobe_n) |-> !addr_latch_strobe && (read_strobe_n || write_strobe_n);
    endproperty
    a_excl: assert property (p_excl) else $error("strobes overlap");
    property p_wrbus;
        !write_strobe_n |-> muxbus_port_lines.oe == 8'hFF;
    endproperty
    a_wrbus: assert property (p_wrbus) else $error("write data not driven");
    c_rd: cover property ($fell(read_strobe_n));
    c_wr: cover property ($fell(write_strobe_n));
    c_ale: cover property ($rose(addr_latch_strobe));
endmodule : pme_top_props
bind pme_top pme_top_props u_props (.aclk(aclk), .aresetn(aresetn), .addr_latch_strobe(addr_latch_strobe),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .muxbus_port_lines(muxbus_port_lines),
    .memsize_select_lo_oe(memsize_select_lo_oe), .memsize_select_hi_oe(memsize_select_hi_oe));
`default_nettype wire

// >>> pme_top_tb.sv
`include "pme_regs.svh"
`default_nettype none
module pme_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] OK = `PME_RESP_OKAY;
    localparam logic [1:0] ER = `PME_RESP_SLVERR;
    // Bus master and pin signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, io_seen, fetch_seen;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [7:0] first_port_lines_in = 8'h00, second_port_lines_in = 8'h00, third_port_lines_in = 8'h00;
    logic [7:0] high_address_port_lines_in = 8'h00, muxbus_port_lines_in, rom_socket_data = 8'h9E;
    logic [7:0] third_port_alt_out = 8'hAA, third_port_alt_oe = 8'hC0;
    logic [7:0] fmask [5] = '{8'h00, 8'h00, 8'h0F, 8'h3F, 8'hFF};
    pme_pkg::pme_port_t first_port_lines, second_port_lines, third_port_lines, muxbus_port_lines, high_address_port_lines;
    logic addr_latch_strobe, read_strobe_n, write_strobe_n, strobe_oe, memsize_select_lo_in, memsize_select_hi_in;
    logic memsize_select_lo_out, memsize_select_lo_oe, memsize_select_hi_out, memsize_select_hi_oe;
    logic [3:0] upper_analog_lines = 4'hF;
    pme_pkg::pme_rom_t rom_socket;
    int error_cnt = 0, n_tests = 0;
    always #5 aclk = ~aclk;
    // Size pins: pull-up on the low one only
    assign memsize_select_lo_in = memsize_select_lo_oe ? memsize_select_lo_out : 1'b1;
    assign memsize_select_hi_in = memsize_select_hi_oe ? memsize_select_hi_out : 1'b0;
    pme_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .first_port_lines_in,
        .first_port_lines, .second_port_lines_in, .second_port_lines, .third_port_lines_in, .third_port_lines,
        .third_port_alt_out, .third_port_alt_oe, .muxbus_port_lines_in, .muxbus_port_lines,
        .high_address_port_lines_in, .high_address_port_lines, .addr_latch_strobe, .read_strobe_n, .write_strobe_n,
        .strobe_oe, .memsize_select_lo_in, .memsize_select_lo_out, .memsize_select_lo_oe, .memsize_select_hi_in,
        .memsize_select_hi_out, .memsize_select_hi_oe, .upper_analog_lines, .rom_socket, .rom_socket_data);
    pme_xmem xmem (.aclk(aclk), .ale(addr_latch_strobe), .rd_n(read_strobe_n), .wr_n(write_strobe_n),
        .lo(muxbus_port_lines), .hi(high_address_port_lines), .bus(muxbus_port_lines_in));
    // Flags seen under each strobe
    always @(posedge aclk) begin
        if (write_strobe_n === 1'b0) io_seen <= memsize_select_lo_out;
        if (read_strobe_n === 1'b0) fetch_seen <= memsize_select_hi_out;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Write both channels together, each released on its own handshake
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask : wr
    task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(32'(s_axi_rresp), 32'(er));
        chk(s_axi_rdata & m, e);
    endtask : rc
    task automatic settle();
        repeat (2) @(posedge aclk);
        #1;
    endtask : settle
    task automatic results();
        $display("mismatches=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (4000) @(posedge aclk);
        error_cnt++;
        results();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        chk(32'({second_port_lines.oe, third_port_lines.oe, muxbus_port_lines.oe}), 32'h0);
        chk(32'({read_strobe_n, write_strobe_n, rom_socket.ce}), 32'h6);
        rc(`PME_OFF_XSTATUS, 32'hE00, 32'h600, OK);
        wr(`PME_OFF_PORTB_DIR, 32'hA5, OK);
        wr(`PME_OFF_PORTB_OUT, 32'h3C, OK);
        wr(`PME_OFF_PORTC_DIR, 32'h0F, OK);
        wr(`PME_OFF_PORTC_ALT, 32'hF0, OK);
        wr(`PME_OFF_PORTC_OUT, 32'h55, OK);
        wr(`PME_OFF_PORTD_DIR, 32'h01, OK);
        settle();
        chk(32'({second_port_lines.oe, second_port_lines.out & 8'hA5}), 32'hA524);
        chk(32'({third_port_lines.oe, third_port_lines.out & 8'hCF}), 32'hCF85);
        chk(32'(muxbus_port_lines.oe == 8'h00 || muxbus_port_lines.oe == 8'hFF), 32'h1);
        wr(`PME_OFF_PORTD_DIR, 32'h00, OK);
        wr(`PME_OFF_PORTF_DIR, 32'hC0, OK);
        // Every expansion mode, upper port bits kept as I/O in all modes below PME_EXP_60K
        for (int m = 0; m < 5; m++) begin
            wr(`PME_OFF_CONFIG, 32'(m), OK);
            if (m == 0) wr(`PME_OFF_XCYCLE, 32'h0100_0000, ER);
            settle();
            chk(32'({strobe_oe, high_address_port_lines.oe}), 32'({m != 0, fmask[m] | 8'hC0}));
        end
        wr(`PME_OFF_XCYCLE, 32'h015A_1234, OK);
        wr(`PME_OFF_XCYCLE, 32'h0100_0000, ER);
        repeat (10) @(posedge aclk);
        chk(32'({io_seen, xmem.mem[16'h1234]}), 32'h15A);
        wr(`PME_OFF_XCYCLE, 32'h0367_1235, OK);
        repeat (10) @(posedge aclk);
        chk(32'({io_seen, xmem.mem[16'h1235]}), 32'h067);
        wr(`PME_OFF_XCYCLE, 32'h0400_1234, OK);
        repeat (10) @(posedge aclk);
        chk(32'(fetch_seen), 32'h0);
        rc(`PME_OFF_XSTATUS, 32'hFF, 32'h5A, OK);
        wr(`PME_OFF_XCYCLE, 32'h0000_FF10, ER);
        rc(`PME_OFF_XSTATUS, 32'h100, 32'h100, OK);
        upper_analog_lines <= 4'hB;
        repeat (4) @(posedge aclk);
        rc(`PME_OFF_ANALOG, 32'hFF, 32'h4B, OK);
        wr(`PME_OFF_ANALOG, 32'h40, OK);
        rc(`PME_OFF_ANALOG, 32'hFF, 32'h0B, OK);
        wr(`PME_OFF_CONFIG, 32'h24, OK);
        rc(`PME_OFF_CONFIG, 32'h30, 32'h00, OK);
        wr(`PME_OFF_CONFIG, 32'h224, OK);
        wr(`PME_OFF_CONFIG, 32'h324, OK);
        rc(`PME_OFF_CONFIG, 32'h30, 32'h20, OK);
        wr(`PME_OFF_PC, 32'hFABC, OK);
        settle();
        chk(32'({rom_socket.ce, rom_socket.addr}), 32'h7ABC);
        rc(`PME_OFF_ROMDATA, 32'hFF, 32'h9E, OK);
        wr(`PME_OFF_CONFIG, 32'h224, OK);
        settle();
        chk(32'(rom_socket.ce), 32'h0);
        rc(12'h100, 32'hFFFF_FFFF, 32'h0, ER);
        results();
    end
endmodule : pme_top_tb
`default_nettype wire
